/* agc_core.sv */
// front end configuration decode, measurement latch and chopper clock
//
// Contract
// - two config words kept; primary used unless alternate selected by command
// - one decode serves whichever word is selected
// - bits 2:0 pick first stage gain 6,12,20,30,40,60,80,120
// - bits 5:3 pick second stage gain 1.1 to 1.8 in 0.1 steps
// - bit 6 set inverts gain by inverting the chopper clock
// - resolution field gives 12 to 24 bits
// - conversion time 140 us at 12 bits up to 6940 us at 24
// - offset shift enabled only when bit 15 is one
// - shift amount comes from bits 14:12
// - active shift adds ADC gain of two to total gain
// - shift off and offset zero gives ADC gain of one
// - offset codes give 0 to 43.25 percent shift of full scale
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module agc_core #(
  parameter int unsigned CYC_PER_US = agc_pkg::SYS_CLK_MHZ,
  parameter logic [15:0] PRI_INIT = agc_pkg::PRI_RESET,
  parameter logic [15:0] ALT_INIT = agc_pkg::ALT_RESET
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic [6:0] g1_gain,
  output logic [4:0] g2_gain_x10,
  output logic chop_clk,
  output logic [4:0] adc_bits,
  output logic adc_shift_en,
  output logic [2:0] adc_offset,
  output logic [12:0] ofs_pct,
  output logic [1:0] adc_gain,
  output logic [12:0] total_gain_x10,
  output logic meas_busy,
  output logic meas_done,
  output logic cfg_invalid
);

  ////////////////////////////////////////////////////////////////////////////
  // register decode
  agc_pkg::agc_bus_s bus;
  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  wire wr_ctrl = bus.wr && (bus.addr == agc_pkg::ADDR_CTRL);
  wire wr_stat = bus.wr && (bus.addr == agc_pkg::ADDR_STAT);
  wire wr_pri = bus.wr && (bus.addr == agc_pkg::ADDR_PRI);
  wire wr_alt = bus.wr && (bus.addr == agc_pkg::ADDR_ALT);

  logic [15:0] pri_q;
  logic [15:0] alt_q;
  logic sel_alt_q;
  logic busy_q;
  logic done_q;
  logic done_flag_q;
  logic [15:0] latch_q;
  logic [23:0] cnt_q;
  logic [4:0] div_q;
  logic phase_q;
  agc_pkg::agc_fields_s act_q;

  ////////////////////////////////////////////////////////////////////////////
  // configuration words and select command
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      pri_q <= PRI_INIT;
      alt_q <= ALT_INIT;
      sel_alt_q <= 1'b0;
    end
    else
    begin
      if (wr_pri)
        pri_q <= bus.wdata;
      if (wr_alt)
        alt_q <= bus.wdata;
      if (wr_ctrl)
        sel_alt_q <= bus.wdata[agc_pkg::CTRL_SEL_BIT];
    end
  end

  wire [15:0] sel_word = sel_alt_q ? alt_q : pri_q;
  agc_pkg::agc_fields_s sel_f;
  assign sel_f = agc_pkg::split_cfg(sel_word);

  ////////////////////////////////////////////////////////////////////////////
  // measurement sequencing
  wire start = wr_ctrl && bus.wdata[agc_pkg::CTRL_START_BIT] && !busy_q;
  wire [31:0] conv_cyc = 32'(agc_pkg::conv_us(sel_f.res_code)) * CYC_PER_US;
  wire finish = busy_q && (cnt_q == 24'h000001);
  wire done_clr = wr_stat && bus.wdata[agc_pkg::STAT_DONE_BIT];

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      done_flag_q <= 1'b0;
      cnt_q <= 24'h000000;
      act_q <= '0;
      latch_q <= 16'h0000;
    end
    else
    begin
      done_q <= finish;
      if (finish)
        done_flag_q <= 1'b1;
      else if (done_clr)
        done_flag_q <= 1'b0;
      if (start)
      begin
        busy_q <= 1'b1;
        act_q <= sel_f;
        latch_q <= sel_word;
        cnt_q <= (conv_cyc == 32'h0) ? 24'h000001 : conv_cyc[23:0];
      end
      else if (busy_q)
      begin
        cnt_q <= cnt_q - 24'h000001;
        if (finish)
          busy_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded outputs from the latched fields
  wire shift_on = act_q.shift_en;
  wire [6:0] g1_d = agc_pkg::g1_value(act_q.g1);
  wire [4:0] g2_d = agc_pkg::G2_X10_BASE + 5'(act_q.g2);
  wire [1:0] adcg_d = shift_on ? agc_pkg::ADC_GAIN_SHIFT
                               : agc_pkg::ADC_GAIN_PLAIN;
  wire [12:0] ofs_d = shift_on ? agc_pkg::ofs_pct_x100(act_q.offset)
                               : 13'h0000;
  wire [12:0] tot_d = 13'(g1_d) * 13'(g2_d) * 13'(adcg_d);
  wire [4:0] bits_d = 5'(agc_pkg::RES_MIN) + 5'(act_q.res_code);
  wire bad_d = !act_q.shift_en && (act_q.offset != 3'h0);

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      g1_gain <= 7'h00;
      g2_gain_x10 <= 5'h00;
      adc_bits <= 5'h00;
      adc_shift_en <= 1'b0;
      adc_offset <= 3'h0;
      ofs_pct <= 13'h0000;
      adc_gain <= 2'h0;
      total_gain_x10 <= 13'h0000;
      cfg_invalid <= 1'b0;
    end
    else
    begin
      g1_gain <= g1_d;
      g2_gain_x10 <= g2_d;
      adc_bits <= bits_d;
      adc_shift_en <= shift_on;
      adc_offset <= act_q.offset;
      ofs_pct <= ofs_d;
      adc_gain <= adcg_d;
      total_gain_x10 <= tot_d;
      cfg_invalid <= bad_d;
    end
  end

  assign meas_busy = busy_q;
  assign meas_done = done_q;

  ////////////////////////////////////////////////////////////////////////////
  // chopper clock, inverted for negative polarity
  wire chop_en = (div_q == 5'(agc_pkg::CHOP_DIV - 1));
  wire phase_d = chop_en ? ~phase_q : phase_q;

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      div_q <= 5'h00;
      phase_q <= 1'b0;
      chop_clk <= 1'b0;
    end
    else
    begin
      div_q <= chop_en ? 5'h00 : div_q + 5'h01;
      phase_q <= phase_d;
      chop_clk <= phase_d ^ act_q.polarity;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port, data in the cycle after the strobe only
  wire [15:0] stat_word = {12'h000, cfg_invalid, sel_alt_q, busy_q,
                           done_flag_q};
  wire [15:0] rd_mux =
    (bus.addr == agc_pkg::ADDR_CTRL) ? {15'h0000, sel_alt_q} :
    (bus.addr == agc_pkg::ADDR_STAT) ? stat_word :
    (bus.addr == agc_pkg::ADDR_LATCH) ? latch_q :
    (bus.addr == agc_pkg::ADDR_PRI) ? pri_q :
    (bus.addr == agc_pkg::ADDR_ALT) ? alt_q : 16'h0000;

  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
      reg_rdata <= 16'h0000;
    else
      reg_rdata <= bus.rd ? rd_mux : 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_select_cmd: assert property (
    wr_ctrl |=> sel_alt_q == $past(bus.wdata[agc_pkg::CTRL_SEL_BIT]))
    else $error("select command not taken");
  a_shared_decode: assert property (
    start |=> act_q == agc_pkg::split_cfg($past(sel_alt_q) ? $past(alt_q)
                                                             : $past(pri_q)))
    else $error("latched fields differ from selected word");
  a_stage1_gain: assert property (
    (!start && !$past(start)) |=> g1_gain == agc_pkg::g1_value(act_q.g1))
    else $error("first stage gain wrong");
  a_stage2_gain: assert property (
    ##1 $stable(act_q) |=> g2_gain_x10 == 5'h0b + 5'($past(act_q.g2)))
    else $error("second stage gain wrong");
  a_chop_invert: assert property (
    $stable(act_q.polarity) && chop_en |=> chop_clk != $past(chop_clk))
    else $error("chopper clock did not toggle");
  a_res_range: assert property (
    adc_bits == 5'h00 || (adc_bits >= 5'h0c && adc_bits <= 5'h18))
    else $error("resolution out of range");
  a_conv_time: assert property (
    start |=> cnt_q == $past(conv_cyc[23:0]) && busy_q)
    else $error("conversion length wrong");
  a_shift_gain: assert property (
    ##1 $stable(act_q) |=> adc_gain == ($past(act_q.shift_en) ? 2'h2 : 2'h1))
    else $error("adc gain does not follow shift bit");
  a_offset_pct: assert property (
    ##1 $stable(act_q) && act_q.shift_en && act_q.offset == 3'h7
      |=> ofs_pct == 13'h10e5)
    else $error("offset percent wrong");
  a_fields_hold: assert property (
    busy_q && !finish |=> $stable(act_q))
    else $error("fields changed during measurement");
  a_done_pulse: assert property (
    finish |=> meas_done ##1 !meas_done)
    else $error("done not a single pulse");
  a_pri_write: assert property (
    wr_pri |=> pri_q == $past(bus.wdata))
    else $error("primary word not written");
  a_alt_write: assert property (
    wr_alt |=> alt_q == $past(bus.wdata))
    else $error("alternate word not written");
  a_select_hold: assert property (
    !wr_ctrl |=> $stable(sel_alt_q))
    else $error("selection changed without command");
  a_read_word: assert property (
    bus.rd && bus.addr == agc_pkg::ADDR_PRI |=> reg_rdata == $past(pri_q))
    else $error("primary word read back wrong");
  a_read_idle: assert property (
    !bus.rd |=> reg_rdata == 16'h0000)
    else $error("read data outside read cycle");
  a_start_latch: assert property (
    start |=> busy_q && latch_q == $past(sel_word))
    else $error("word not latched at start");
  a_busy_hold: assert property (
    busy_q && !finish |=> busy_q && $stable(latch_q))
    else $error("measurement cut or restarted");
  a_done_sticky: assert property (
    finish |=> done_flag_q)
    else $error("done flag not set");
  a_res_clamp: assert property (
    act_q.res_code <= agc_pkg::RES_CODE_MAX)
    else $error("resolution code above 24 bits");
  a_shift_out: assert property (
    ##1 $stable(act_q) |=> adc_shift_en == $past(act_q.shift_en))
    else $error("shift enable output wrong");
  a_offset_out: assert property (
    ##1 $stable(act_q) |=> adc_offset == $past(act_q.offset))
    else $error("offset output wrong");
  a_shift_off: assert property (
    ##1 $stable(act_q) && !act_q.shift_en
      |=> ofs_pct == 13'h0000 && adc_gain == 2'h1)
    else $error("shift applied while disabled");
  a_total_gain: assert property (
    total_gain_x10 == 13'(g1_gain) * 13'(g2_gain_x10) * 13'(adc_gain))
    else $error("total gain not product of stages");
  a_invalid_flag: assert property (
    ##1 $stable(act_q) |=> cfg_invalid ==
      (!$past(act_q.shift_en) && $past(act_q.offset) != 3'h0))
    else $error("invalid combination flag wrong");
  a_chop_polarity: assert property (
    $changed(act_q.polarity) && !chop_en |=> chop_clk != $past(chop_clk))
    else $error("polarity change did not invert chopper clock");

endmodule
`default_nettype wire

/* agc_pkg.sv */
// package: register map, field layout and decode tables for the front end
package agc_pkg;
  localparam int unsigned SYS_CLK_MHZ = 40;
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 16;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_LATCH = 8'h08;
  localparam logic [7:0] ADDR_PRI = 8'h12;
  localparam logic [7:0] ADDR_ALT = 8'h16;
  localparam logic [15:0] PRI_RESET = 16'h0000;
  localparam logic [15:0] ALT_RESET = 16'h0000;
  localparam int unsigned CTRL_SEL_BIT = 0;
  localparam int unsigned CTRL_START_BIT = 1;
  localparam int unsigned STAT_DONE_BIT = 0;
  localparam int unsigned G1_LSB = 0;
  localparam int unsigned G2_LSB = 3;
  localparam int unsigned POL_BIT = 6;
  localparam int unsigned RES_LSB = 7;
  localparam int unsigned OFS_LSB = 12;
  localparam int unsigned SHIFT_BIT = 15;
  localparam int unsigned RES_MIN = 12;
  localparam int unsigned RES_MAX = 24;
  localparam logic [3:0] RES_CODE_MAX = 4'hc;
  localparam logic [4:0] G2_X10_BASE = 5'h0b;
  localparam logic [1:0] ADC_GAIN_SHIFT = 2'h2;
  localparam logic [1:0] ADC_GAIN_PLAIN = 2'h1;
  localparam int unsigned CHOP_DIV = 20;

  typedef struct packed {
    logic shift_en;
    logic [2:0] offset;
    logic [3:0] res_code;
    logic polarity;
    logic [2:0] g2;
    logic [2:0] g1;
  } agc_fields_s;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } agc_bus_s;

  // split a configuration word; same layout for both words
  function automatic agc_fields_s split_cfg(input logic [15:0] w);
    agc_fields_s f;
    f.shift_en = w[SHIFT_BIT];
    f.offset = w[OFS_LSB +: 3];
    f.res_code = (w[RES_LSB +: 4] > RES_CODE_MAX) ? RES_CODE_MAX
                                                  : w[RES_LSB +: 4];
    f.polarity = w[POL_BIT];
    f.g2 = w[G2_LSB +: 3];
    f.g1 = w[G1_LSB +: 3];
    return f;
  endfunction

  function automatic logic [6:0] g1_value(input logic [2:0] c);
    case (c)
      3'h0: return 7'h06;
      3'h1: return 7'h0c;
      3'h2: return 7'h14;
      3'h3: return 7'h1e;
      3'h4: return 7'h28;
      3'h5: return 7'h3c;
      3'h6: return 7'h50;
      default: return 7'h78;
    endcase
  endfunction

  // offset shift in hundredths of a percent of full scale
  function automatic logic [12:0] ofs_pct_x100(input logic [2:0] c);
    case (c)
      3'h0: return 13'h0000;
      3'h1: return 13'h02a3;
      3'h2: return 13'h04e2;
      3'h3: return 13'h0785;
      3'h4: return 13'h09c4;
      3'h5: return 13'h0c67;
      3'h6: return 13'h0f0a;
      default: return 13'h10e5;
    endcase
  endfunction

  // typical single conversion time in microseconds per resolution code
  function automatic logic [12:0] conv_us(input logic [3:0] c);
    case (c)
      4'h0: return 13'h008c;
      4'h1: return 13'h00b9;
      4'h2: return 13'h00fa;
      4'h3: return 13'h014f;
      4'h4: return 13'h01d6;
      4'h5: return 13'h0280;
      4'h6: return 13'h037a;
      4'h7: return 13'h04e2;
      4'h8: return 13'h06e0;
      4'h9: return 13'h099c;
      4'ha: return 13'h0d98;
      4'hb: return 13'h131a;
      default: return 13'h1b1c;
    endcase
  endfunction
endpackage

/* agc_sensor_model.sv */
// sensor side model: watches the chopper clock that drives the bridge
`timescale 1ns/1ps
`default_nettype none
module agc_sensor_model (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic chop_clk,
  output logic [7:0] half_q,
  output logic lvl_q
);
  logic [7:0] run_q;
  logic [5:0] ph_q;
  logic last_q;
  logic edge_w;
  assign edge_w = chop_clk != last_q;
  always_ff @(posedge sys_clk)
  begin
    last_q <= chop_clk;
    run_q <= (edge_w || !rstn) ? 8'h01 : run_q + 8'h01;
    ph_q <= (!rstn || ph_q == 6'h27) ? 6'h00 : ph_q + 6'h01;
    if (edge_w)
      half_q <= run_q;
    if (ph_q == 6'h05)
      lvl_q <= chop_clk;
  end
endmodule
`default_nettype wire

/* tb.sv */
// testbench: register access, measurement decode and timing
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [6:0] g1_gain;
  logic [4:0] g2_gain_x10;
  logic chop_clk;
  logic [4:0] adc_bits;
  logic adc_shift_en;
  logic [2:0] adc_offset;
  logic [12:0] ofs_pct;
  logic [1:0] adc_gain;
  logic [12:0] total_gain_x10;
  logic meas_busy;
  logic meas_done;
  logic cfg_invalid;
  logic [7:0] half_cnt;
  logic phase_lvl;
  logic ref_lvl;
  int n_mismatch = 0;
  int checks = 0;
  logic [12:0] ct [13] = '{140, 185, 250, 335, 470, 640, 890, 1250, 1760,
    2460, 3480, 4890, 6940};
  logic [6:0] gt [8] = '{6, 12, 20, 30, 40, 60, 80, 120};
  logic [12:0] ot [8] = '{0, 675, 1250, 1925, 2500, 3175, 3850, 4325};

  agc_core #(.CYC_PER_US(1)) DUT (.sys_clk(sys_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .g1_gain(g1_gain),
    .g2_gain_x10(g2_gain_x10), .chop_clk(chop_clk), .adc_bits(adc_bits),
    .adc_shift_en(adc_shift_en), .adc_offset(adc_offset),
    .ofs_pct(ofs_pct), .adc_gain(adc_gain),
    .total_gain_x10(total_gain_x10), .meas_busy(meas_busy),
    .meas_done(meas_done), .cfg_invalid(cfg_invalid));
  agc_sensor_model sensor (.sys_clk(sys_clk), .rstn(rstn),
    .chop_clk(chop_clk), .half_q(half_cnt), .lvl_q(phase_lvl));

  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen,
    input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [7:0] a,
    input logic [15:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, reg_rdata, exp);
  endtask

  // start one measurement; a second start and a primary write land mid-run
  task automatic meas(input logic sel, input logic [15:0] w);
    logic [3:0] rc;
    logic [15:0] ex;
    logic inv;
    int n;
    rc = (w[10:7] > 4'hc) ? 4'hc : w[10:7];
    inv = !w[15] && w[14:12] != 3'h0;
    ex = 16'(gt[w[2:0]]) * (16'h000b + w[5:3]) * (w[15] ? 16'h2 : 16'h1);
    n = 0;
    wr(sel ? agc_pkg::ADDR_ALT : agc_pkg::ADDR_PRI, w);
    wr(agc_pkg::ADDR_CTRL, {15'h0000, sel});
    @(posedge sys_clk);
    reg_addr <= agc_pkg::ADDR_CTRL;
    reg_wdata <= {14'h0000, 1'b1, sel};
    reg_wr <= 1'b1;
    while (meas_done !== 1'b1 && n < 8000)
    begin
      @(posedge sys_clk);
      reg_wr <= (n == 10 || n == 20);
      reg_addr <= (n == 20) ? agc_pkg::ADDR_PRI : agc_pkg::ADDR_CTRL;
      reg_wdata <= (n == 20) ? 16'hffff : {14'h0000, 1'b1, sel};
      #1;
      if (meas_busy === 1'b1)
        n++;
    end
    chk("busy cycles", 16'(n), {3'h0, ct[rc]});
    chk("busy at done", {15'h0000, meas_busy}, 16'h0000);
    chk("g1", {9'h000, g1_gain}, {9'h000, gt[w[2:0]]});
    chk("g2", {11'h000, g2_gain_x10}, 16'h000b + w[5:3]);
    chk("bits", {11'h000, adc_bits}, 16'h000c + rc);
    chk("shift", {15'h0000, adc_shift_en}, {15'h0000, w[15]});
    chk("offset", {13'h0000, adc_offset}, {13'h0000, w[14:12]});
    chk("pct", {3'h0, ofs_pct}, w[15] ? {3'h0, ot[w[14:12]]} : 16'h0);
    chk("adc gain", {14'h0000, adc_gain}, w[15] ? 16'h2 : 16'h1);
    chk("total", {3'h0, total_gain_x10}, ex);
    chk("invalid", {15'h0000, cfg_invalid}, {15'h0000, inv});
    chk("half period", {8'h00, half_cnt}, 16'h0014);
    chk("chop phase", {15'h0000, phase_lvl}, {15'h0000, ref_lvl ^ w[6]});
    rd("latched", agc_pkg::ADDR_LATCH, w);
    rd("word", sel ? agc_pkg::ADDR_ALT : agc_pkg::ADDR_PRI,
      sel ? w : 16'hffff);
    rd("status", agc_pkg::ADDR_STAT, {12'h000, inv, sel, 2'h1});
    wr(agc_pkg::ADDR_STAT, 16'h0001);
    rd("status clr", agc_pkg::ADDR_STAT, {12'h000, inv, sel, 2'h0});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (100) @(posedge sys_clk);
    ref_lvl = phase_lvl;
    rd("pri reset", agc_pkg::ADDR_PRI, agc_pkg::PRI_RESET);
    rd("alt reset", agc_pkg::ADDR_ALT, agc_pkg::ALT_RESET);
    wr(8'h20, 16'h5a5a);
    rd("unmapped", 8'h20, 16'h0000);
    for (int i = 0; i < 8; i++)
      meas(i[0], {i != 0, i[2:0], 1'b0, 4'(i + 5), i[0], i[2:0],
        3'(7 - i)});
    meas(1'b0, 16'h8000);
    meas(1'b1, 16'h3780);
    close_out();
  end

  initial
  begin
    repeat (40000) @(posedge sys_clk);
    n_mismatch++;
    close_out();
  end
endmodule
`default_nettype wire
